// ===== core/dacl_pkg.sv
// constants and carrier types of the two-rank converter load controller
package dacl_pkg;
	// clock and documented widths
	localparam int CLK_MHZ = 200;
	localparam int WORD_W  = 16;
	localparam int BYTE_W  = 8;
	localparam int UNIT_W  = 4;
	localparam int CNT_W   = 8;

	// pin timing in ns, least figures
	localparam int SETUP_NS  = 10;
	localparam int STROBE_NS = 50;
	localparam int HOLD_NS   = 10;
	localparam int GAP_NS    = 100;

	// least times round up to whole cycles
	localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC   = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC    = (GAP_NS * CLK_MHZ + 999) / 1000;

	// counter load values, one less than the cycle counts
	localparam logic [CNT_W-1:0] SETUP_LD  = CNT_W'(SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(STROBE_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_LD   = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LD    = CNT_W'(GAP_CYC - 1);

	// commands from the user side
	typedef enum logic [1:0] {
		DACL_OP_LOAD,
		DACL_OP_UPDATE,
		DACL_OP_TIED
	} dacl_op_e;

	typedef struct packed {
		dacl_op_e           op;
		logic [UNIT_W-1:0]  unit;
		logic [WORD_W-1:0]  word;
	} dacl_cmd_s;

	// shared pins toward the converters
	typedef struct packed {
		logic               load_n;
		logic               update;
		logic               byte_le;
		logic [WORD_W-1:0]  word;
	} dacl_pins_s;

	localparam dacl_pins_s PINS_RST = '{
		load_n: 1'b1, update: 1'b0, byte_le: 1'b0, word: 16'h0000};
endpackage

// ===== core/dacl_host.sv
// host controller that loads and updates a bank of two-rank converters
//
// How it works
// RL1 - first rank passes while select, load low
// RL2 - second rank follows first while update high
// RL3 - update pin ignores select and other controls
// RL4 - one select on all pins acts as register
// RL5 - tied select rising edge captures and updates
// RL6 - select low time stretched to device minimum
// RL7 - each write finishes without wait states
// RL8 - unit address captured before select decode; 16-bit and tied writes decode it straight from the command
// RL9 - only the addressed converter's latch opens
// RL10 - data captured on load strobe rising edge
// RL11 - select never outlasts the data on bus
// RL12 - load units separately, then one shared update
// RL13 - update write gives high-going update pulse
// RL14 - update falling edge freezes second rank
// RL15 - byte bus builds word via holding latch
// RL16 - upper byte caught by lowering latch enable
// RL17 - lower byte then select and load together (here select falls with the lower byte, load SETUP_CYC cycles later)
// RL18 - output code moves only while update high
`timescale 1ns/100ps

module dacl_host #(
	parameter int N_UNITS = 4,
	parameter int BUS_W   = 16
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// command port
	input  wire logic                    cmd_valid,
	output logic                         cmd_ready,
	input  wire dacl_pkg::dacl_cmd_s     cmd,
	// converter pins
	output logic [N_UNITS-1:0]           decoded_select_n,
	output logic                         first_rank_load_n,
	output logic                         second_rank_update,
	output logic                         byte_latch_en,
	output logic [BUS_W-1:0]             input_word
);

	// refuse shapes the sequencer cannot drive
	if (BUS_W != dacl_pkg::WORD_W && BUS_W != dacl_pkg::BYTE_W)
	begin : g_bad_bus
		$error("bus width must be 8 or 16");
	end
	if (N_UNITS < 1 || N_UNITS > (1 << dacl_pkg::UNIT_W))
	begin : g_bad_units
		$error("unit count out of range");
	end

	localparam bit BYTE_BUS = (BUS_W == dacl_pkg::BYTE_W);
	localparam logic [N_UNITS-1:0] UNIT_ONE = N_UNITS'(1);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_HI_BYTE,
		ST_HI_LATCH,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_GAP,
		ST_UPDATE,
		ST_TIED_LOW,
		ST_TIED_HOLD
	} dacl_state_e;

	dacl_state_e                    st_q, st_d;
	logic [dacl_pkg::CNT_W-1:0]     cnt_q, cnt_d;
	logic [N_UNITS-1:0]             sel_q, sel_d;
	logic [dacl_pkg::WORD_W-1:0]    word_q, word_d;
	dacl_pkg::dacl_pins_s           pins_q, pins_d;
	logic                           done;
	// unit index kept for the second byte phase
	logic [dacl_pkg::UNIT_W-1:0]    cmd_unit_q, cmd_unit_d;

	// handshake is combinational; only idle takes a command
	assign cmd_ready = (st_q == ST_IDLE);

	// pins come straight from flops, so no decode glitches reach them
	assign decoded_select_n   = sel_q;
	assign first_rank_load_n  = pins_q.load_n;
	assign second_rank_update = pins_q.update;
	assign byte_latch_en      = pins_q.byte_le;
	assign input_word         = pins_q.word[BUS_W-1:0];

	// sequencer next state
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sel_d  = sel_q;
		word_d = word_q;
		pins_d = pins_q;
		done   = (cnt_q == '0);
		if (!done)
			cnt_d = cnt_q - 1'b1;
		case (st_q)
			ST_IDLE:
			begin
				if (cmd_valid)
				begin
					// unit is taken here; 16-bit and tied selects move on this same edge
					word_d = cmd.word; // RL8
					case (cmd.op)
						dacl_pkg::DACL_OP_LOAD:
						begin
							// unknown units are dropped without a pulse
							if (int'(cmd.unit) >= N_UNITS)
								st_d = ST_IDLE;
							else if (BYTE_BUS)
							begin
								// upper byte first through the open latch
								st_d = ST_HI_BYTE; // RL15
								pins_d.word = {{dacl_pkg::BYTE_W{1'b0}},
									cmd.word[dacl_pkg::WORD_W-1:
									dacl_pkg::BYTE_W]};
								pins_d.byte_le = 1'b1;
								cnt_d = dacl_pkg::SETUP_LD;
							end
							else
							begin
								st_d = ST_SETUP;
								pins_d.word = cmd.word;
								sel_d = ~(UNIT_ONE << cmd.unit); // RL9
								cnt_d = dacl_pkg::SETUP_LD;
							end
						end
						dacl_pkg::DACL_OP_UPDATE:
						begin
							// settle gap lowers bit skew across units
							st_d = ST_GAP; // RL12
							cnt_d = dacl_pkg::GAP_LD;
						end
						dacl_pkg::DACL_OP_TIED:
						begin
							if (int'(cmd.unit) < N_UNITS)
							begin
								st_d = ST_TIED_LOW; // RL4
								pins_d.word = cmd.word;
								sel_d = ~(UNIT_ONE << cmd.unit);
								cnt_d = dacl_pkg::STROBE_LD;
							end
						end
						default:
							st_d = ST_IDLE;
					endcase
					if (cmd.op == dacl_pkg::DACL_OP_LOAD && BYTE_BUS
						&& int'(cmd.unit) < N_UNITS)
						sel_d = sel_q;
				end
			end
			ST_HI_BYTE:
			begin
				if (done)
				begin
					// lowering latch enable holds the upper byte
					st_d = ST_HI_LATCH;
					pins_d.byte_le = 1'b0; // RL16
					cnt_d = dacl_pkg::HOLD_LD;
				end
			end
			ST_HI_LATCH:
			begin
				if (done)
				begin
					// lower byte on the bus and the addressed unit opened in the same cycle
					st_d = ST_SETUP; // RL17
					pins_d.word = {{dacl_pkg::BYTE_W{1'b0}},
						word_q[dacl_pkg::BYTE_W-1:0]};
					sel_d = ~(UNIT_ONE << cmd_unit_q);
					cnt_d = dacl_pkg::SETUP_LD;
				end
			end
			ST_SETUP:
			begin
				if (done)
				begin
					// first rank opens while select and load both low
					st_d = ST_STROBE; // RL1
					pins_d.load_n = 1'b0; // RL17
					cnt_d = dacl_pkg::STROBE_LD; // RL6
				end
			end
			ST_STROBE:
			begin
				if (done)
				begin
					// capture on load rising edge, select still low
					st_d = ST_HOLD;
					pins_d.load_n = 1'b1; // RL10
					cnt_d = dacl_pkg::HOLD_LD;
				end
			end
			ST_HOLD:
			begin
				if (done)
				begin
					// select lifts before data may change
					st_d = ST_IDLE; // RL11
					sel_d = '1;
				end
			end
			ST_GAP:
			begin
				if (done)
				begin
					// update pulse never touches select or load
					st_d = ST_UPDATE;
					pins_d.update = 1'b1; // RL13
					cnt_d = dacl_pkg::STROBE_LD;
				end
			end
			ST_UPDATE:
			begin
				if (done)
				begin
					// falling update freezes the new code in all units
					st_d = ST_IDLE;
					pins_d.update = 1'b0; // RL14
				end
			end
			ST_TIED_LOW:
			begin
				if (done)
				begin
					// one rising edge latches and updates the unit
					st_d = ST_TIED_HOLD; // RL5
					sel_d = '1;
					cnt_d = dacl_pkg::HOLD_LD;
				end
			end
			ST_TIED_HOLD:
			begin
				// data held past the rising select edge
				if (done)
					st_d = ST_IDLE; // RL11
			end
			default:
			begin
				st_d = ST_IDLE;
				sel_d = '1;
				pins_d = dacl_pkg::PINS_RST;
			end
		endcase
	end

	// unit index is captured with the command; 16-bit and tied selects move on that same edge
	always_comb
	begin
		cmd_unit_d = cmd_unit_q;
		if (st_q == ST_IDLE && cmd_valid)
			cmd_unit_d = cmd.unit; // RL8
	end

	// sequencer registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q       <= ST_IDLE;
			cnt_q      <= '0;
			sel_q      <= '1;
			word_q     <= 16'h0000;
			pins_q     <= dacl_pkg::PINS_RST;
			cmd_unit_q <= 4'h0;
		end
		else
		begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			sel_q      <= sel_d;
			word_q     <= word_d;
			pins_q     <= pins_d;
			cmd_unit_q <= cmd_unit_d;
		end
	end

	// helper counters read only by the checks below
	logic [7:0] ld_low_q, ld_low_d;
	logic [7:0] sel_low_q, sel_low_d;
	logic [7:0] since_ld_q, since_ld_d;

	always_comb
	begin
		ld_low_d   = 8'h00;
		sel_low_d  = 8'h00;
		since_ld_d = since_ld_q;
		if (!pins_q.load_n && ld_low_q != 8'hff)
			ld_low_d = ld_low_q + 8'h01;
		if (!(&sel_q) && sel_low_q != 8'hff)
			sel_low_d = sel_low_q + 8'h01;
		if (!pins_q.load_n || !(&sel_q))
			since_ld_d = 8'h00;
		else if (since_ld_q != 8'hff)
			since_ld_d = since_ld_q + 8'h01;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ld_low_q   <= 8'h00;
			sel_low_q  <= 8'h00;
			since_ld_q <= 8'hff;
		end
		else
		begin
			ld_low_q   <= ld_low_d;
			sel_low_q  <= sel_low_d;
			since_ld_q <= since_ld_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// a load strobe is low then high again
	sequence s_capture;
		!pins_q.load_n ##1 pins_q.load_n;
	endsequence

	sequence s_deselect;
		!(&sel_q) ##1 (&sel_q);
	endsequence

	property p_strobe_width;
		s_capture |-> ld_low_q >= 8'(dacl_pkg::STROBE_CYC);
	endproperty
	a_strobe_width: assert property (p_strobe_width) // RL6
		else $error("load strobe shorter than minimum");

	property p_capture_sel;
		s_capture |-> !(&sel_q) && $stable(pins_q.word);
	endproperty
	a_capture_sel: assert property (p_capture_sel) // RL10
		else $error("strobe rose without select or with new data");

	property p_sel_hold;
		s_deselect |-> $stable(pins_q.word);
	endproperty
	a_sel_hold: assert property (p_sel_hold) // RL11
		else $error("data changed as select rose");

	property p_one_unit;
		$onehot0(~sel_q);
	endproperty
	a_one_unit: assert property (p_one_unit) // RL9
		else $error("more than one converter selected");

	property p_update_alone;
		pins_q.update |-> (&sel_q) && pins_q.load_n;
	endproperty
	a_update_alone: assert property (p_update_alone) // RL13
		else $error("update pulse overlaps a load");

	property p_update_gap;
		$rose(pins_q.update) |-> since_ld_q >= 8'(dacl_pkg::GAP_CYC);
	endproperty
	a_update_gap: assert property (p_update_gap) // RL12
		else $error("update too close to last load");

	property p_sel_width;
		s_deselect |-> sel_low_q >= 8'(dacl_pkg::STROBE_CYC);
	endproperty
	a_sel_width: assert property (p_sel_width) // RL4
		else $error("select low time too short");

	property p_byte_closed;
		$fell(pins_q.load_n) |-> !pins_q.byte_le && !(&sel_q);
	endproperty
	a_byte_closed: assert property (p_byte_closed) // RL16
		else $error("load began with byte latch open or no select");

	property p_no_wait;
		cmd_valid && cmd_ready |=> ##[1:60] cmd_ready;
	endproperty
	a_no_wait: assert property (p_no_wait) // RL7
		else $error("write did not finish in bounded time");

endmodule

// ===== testbench/dacl_conv_model.sv
// behavioural two-rank converter seen from its control and data pins
`timescale 1ns/100ps

module dacl_conv_model (
	// control pins
	input  wire logic                        select_n,
	input  wire logic                        load_n,
	input  wire logic                        update,
	// data in, code out
	input  wire logic [dacl_pkg::WORD_W-1:0] word,
	output logic      [dacl_pkg::WORD_W-1:0] code
);
	logic [dacl_pkg::WORD_W-1:0] rank1_q = 16'h0000;

	initial code = 16'h0000;

	// first rank open only while both lows meet, held once either rises
	always @(*)
		if (!select_n && !load_n)
			rank1_q = word;

	// update is not gated by select, so one shared pin moves every unit
	always @(*)
		if (update)
			code = rank1_q;
endmodule

// ===== testbench/tb_dacl_host.sv
// self-checking bench for the two-rank converter load controller
`timescale 1ns/100ps

module tb_dacl_host;
	typedef struct {
		dacl_pkg::dacl_op_e op;
		logic [3:0]         unit;
		logic [15:0]        word;
		int                 cu;
		logic [15:0]        exp;
	} dacl_row_s;

	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                cmd_valid = 1'b0;
	logic                cmd_ready;
	dacl_pkg::dacl_cmd_s cmd = '0;
	logic [3:0]          sel_n;
	logic                load_n;
	logic                update;
	logic                byte_le;
	logic [15:0]         bus;
	logic [15:0]         bus_prev;
	logic [3:0]          sel_prev = 4'hf;
	logic [15:0]         code [4];
	int                  n_mismatch = 0;
	int                  tests_run = 0;
	int                  cycles = 0;
	int                  lo_cnt = 0;
	int                  hi_cnt = 0;
	// byte-bus controller with its holding latch and one converter
	logic                cmd_valid8 = 1'b0;
	logic                cmd_ready8;
	logic [3:0]          sel8;
	logic                load8;
	logic                upd8;
	logic                byte_le8;
	logic [7:0]          bus8;
	logic [7:0]          hi_byte_q = 8'h00;
	logic [15:0]         code8;

	// unit 4 does not exist: a truncated index would hit unit 0
	dacl_row_s rows [10] = '{
		'{dacl_pkg::DACL_OP_LOAD,   4'h0, 16'h1234, 0, 16'h0000},
		'{dacl_pkg::DACL_OP_LOAD,   4'h1, 16'habcd, 1, 16'h0000},
		'{dacl_pkg::DACL_OP_LOAD,   4'h2, 16'hffff, 2, 16'h0000},
		'{dacl_pkg::DACL_OP_UPDATE, 4'h0, 16'h0000, 0, 16'h1234},
		'{dacl_pkg::DACL_OP_LOAD,   4'h0, 16'h8000, 0, 16'h1234},
		'{dacl_pkg::DACL_OP_UPDATE, 4'h0, 16'h0000, 1, 16'habcd},
		'{dacl_pkg::DACL_OP_TIED,   4'h3, 16'h5a5a, 3, 16'h5a5a},
		'{dacl_pkg::DACL_OP_TIED,   4'h3, 16'h0001, 3, 16'h0001},
		'{dacl_pkg::DACL_OP_LOAD,   4'h4, 16'h0f0f, 0, 16'h8000},
		'{dacl_pkg::DACL_OP_UPDATE, 4'h0, 16'h0000, 0, 16'h8000}
	};

	always #2.5 clk = ~clk;

	dacl_host #(.N_UNITS(4), .BUS_W(16)) u_dut (
		.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .decoded_select_n(sel_n),
		.first_rank_load_n(load_n), .second_rank_update(update),
		.byte_latch_en(byte_le), .input_word(bus));

	// three plain units share load and update
	for (genvar i = 0; i < 3; i++)
	begin : g_unit
		dacl_conv_model u_conv (.select_n(sel_n[i]), .load_n(load_n),
			.update(update), .word(bus), .code(code[i]));
	end
	// unit 3 has every control strapped to its select: an edge register
	dacl_conv_model u_tied (.select_n(sel_n[3]), .load_n(sel_n[3]),
		.update(sel_n[3]), .word(bus), .code(code[3]));

	dacl_host #(.N_UNITS(4), .BUS_W(8)) u_dut8 (
		.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid8),
		.cmd_ready(cmd_ready8), .cmd(cmd), .decoded_select_n(sel8),
		.first_rank_load_n(load8), .second_rank_update(upd8),
		.byte_latch_en(byte_le8), .input_word(bus8));

	// external octal latch: open while enable high, holds once it falls
	always @(*)
		if (byte_le8)
			hi_byte_q = bus8;

	dacl_conv_model u_conv8 (.select_n(sel8[0]), .load_n(load8),
		.update(upd8), .word({hi_byte_q, bus8}), .code(code8));

	task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		tests_run++;
		if (got != exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// offer one command, then wait a bounded time for idle
	task automatic send(input dacl_pkg::dacl_op_e op, input logic [3:0] unit,
		input logic [15:0] word);
		int n;
		n = 0;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = '{op: op, unit: unit, word: word};
		@(negedge clk);
		cmd_valid = 1'b0;
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk_pin({3'h0, cmd_ready}, 4'h1);
	endtask

	// same offer on the byte-bus controller
	task automatic send8(input dacl_pkg::dacl_op_e op, input logic [15:0] word);
		int n;
		n = 0;
		@(negedge clk);
		cmd_valid8 = 1'b1;
		cmd = '{op: op, unit: 4'h0, word: word};
		@(negedge clk);
		cmd_valid8 = 1'b0;
		while (cmd_ready8 !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk_pin({3'h0, cmd_ready8}, 4'h1);
	endtask

	// pin watch on the falling edge, where registered pins have settled
	always @(negedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			give_verdict();
		end
		if (rst_n)
		begin
			if (!load_n)
				chk_cnt($countones(~sel_n), 1);
			if (update)
				chk_pin(sel_n, 4'hf);
			if (~sel_prev != 4'h0)
				chk_code(bus, bus_prev);
			lo_cnt = load_n ? lo_cnt : lo_cnt + 1;
			hi_cnt = update ? hi_cnt + 1 : hi_cnt;
			if (load_n && lo_cnt != 0)
				chk_cnt(lo_cnt, dacl_pkg::STROBE_CYC);
			if (!update && hi_cnt != 0)
				chk_cnt(hi_cnt, dacl_pkg::STROBE_CYC);
			lo_cnt = load_n ? 0 : lo_cnt;
			hi_cnt = update ? hi_cnt : 0;
			sel_prev = sel_n;
		end
		else
		begin
			lo_cnt = 0;
			hi_cnt = 0;
			sel_prev = 4'hf;
		end
		bus_prev = bus;
	end

	// main sequence: table first, then one reset case and the byte bus by hand
	initial
	begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		chk_pin(sel_n, 4'hf);
		chk_pin({load_n, update, byte_le, cmd_ready}, 4'h9);
		foreach (rows[i])
		begin
			send(rows[i].op, rows[i].unit, rows[i].word);
			chk_code(code[rows[i].cu], rows[i].exp);
		end
		// reset lands while unit 1 is open; its output must not move
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = '{op: dacl_pkg::DACL_OP_LOAD, unit: 4'h1, word: 16'h1111};
		@(negedge clk);
		cmd_valid = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b0;
		#1;
		chk_pin(sel_n, 4'hf);
		chk_pin({load_n, update, byte_le, cmd_ready}, 4'h9);
		chk_code(code[1], 16'habcd);
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		send(dacl_pkg::DACL_OP_UPDATE, 4'h0, 16'h0000);
		chk_code(code[1], 16'h1111);
		// byte bus: upper byte through the latch, then lower byte
		send8(dacl_pkg::DACL_OP_LOAD, 16'hc3a5);
		chk_code(code8, 16'h0000);
		send8(dacl_pkg::DACL_OP_UPDATE, 16'h0000);
		chk_code(code8, 16'hc3a5);
		give_verdict();
	end
endmodule
